// ===== design/pssc_top.sv
// soft strap control block: strap registers, latch pulse and strap effects
// Operation
// - fields written, config done pulses, straps latched
// - peer link drop disables transmitter when forced
// - fast link-up bit selects parallel detect speed
// - crossover fast or robust forces fast link-up
// - extended duplex forces full duplex when partner forced
// - led link only for full duplex option
// - isolate mii outputs on half duplex 100
// - idle symbol error detect, default on
// - odd nibble check disabled by bit one
// - odd nibble fall extends enable as error
// - rmii receive clock reference select bit zero
`timescale 1ns/1ns
`include "pssc_map.svh"

module pssc_top
    import pssc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pssc_link_s link,
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    output logic strap_reset_pulse,
    output logic tx_disable,
    output logic fast_pd_link_up,
    output logic duplex_full,
    output logic led_link,
    output logic mii_isolate,
    output logic rx_er_idle,
    output logic rmii_rx_clk_ref,
    output logic tx_en_out,
    output logic tx_er_out
);

    pssc_req_s req;
    logic [7:0] rd_idx;
    logic [31:0] rd_data;
    logic [1:0] mdix_mode;
    logic mdix_fast_any;
    logic configured;
    pssc_two_s strap_two;
    pssc_two_s latched;

    // true when a bus write lands on the given register
    function automatic logic wr_hit(input pssc_req_s r, input logic [7:0] i);
        return r.wr && (r.idx == i);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus front end
    pssc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .req(req),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // first strap register: crossover mode bits kept here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdix_mode <= `PSSC_ONE_MDIX_RESET;
        end else if (wr_hit(req, `PSSC_IDX_ONE)) begin
            mdix_mode <= req.wdata[`PSSC_ONE_FAST_MDIX:`PSSC_ONE_ROBUST_MDIX];
        end
    end

    assign mdix_fast_any = |mdix_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_reset_pulse <= 1'b0;
        end else begin
            strap_reset_pulse <= wr_hit(req, `PSSC_IDX_ONE) & req.wdata[`PSSC_ONE_CFG_DONE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // second strap register; all bits writable, reserved ones included
    // reserved resets to two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_two <= `PSSC_TWO_RESET;
        end else begin
            if (wr_hit(req, `PSSC_IDX_TWO)) begin
                strap_two <= req.wdata[15:0];
            end
            // forcing wins over a software write of zero
            if (mdix_fast_any) begin
                strap_two.fast_pd_link_up <= 1'b1;
            end
        end
    end

    // straps latched on pulse
    // the effects only follow the registers after the latch, like real pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latched <= `PSSC_TWO_RESET;
            configured <= 1'b0;
        end else if (strap_reset_pulse) begin
            // forcing latched too
            // the done write may select crossover one cycle before the copy is taken, while strap_two is not yet forced
            latched <= strap_two | {9'h0, mdix_fast_any, 6'h0};
            configured <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped indices read zero
    always_comb begin
        rd_data = 32'h0;
        unique case (rd_idx)
            `PSSC_IDX_ONE: begin
                rd_data[`PSSC_ONE_FAST_MDIX:`PSSC_ONE_ROBUST_MDIX] = mdix_mode;
            end
            `PSSC_IDX_TWO: begin
                rd_data[15:0] = strap_two;
            end
            `PSSC_IDX_STATUS: begin
                rd_data[15:0] = latched;
                rd_data[`PSSC_STAT_CONFIGURED] = configured;
            end
            default: begin
                rd_data = 32'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter off on drop
    // only meaningful while forced to 100, so auto-negotiated links ignore it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_disable <= 1'b0;
        end else begin
            tx_disable <= latched.peer_link_drop_on_failure & link.forced_100 & ~link.link_up;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_pd_link_up <= 1'b0;
        end else begin
            fast_pd_link_up <= latched.fast_pd_link_up;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duplex_full <= 1'b0;
        end else if (latched.forced_partner_full_duplex_enable & link.partner_forced_100 &
                     (link.auto_neg | link.forced_100)) begin
            duplex_full <= 1'b1;
        end else begin
            duplex_full <= link.ieee_full_duplex;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_link <= 1'b0;
        end else begin
            led_link <= link.link_up & (~latched.led_link_full_duplex_only |
                        (link.speed_100 & link.ieee_full_duplex));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mii_isolate <= 1'b0;
        end else begin
            mii_isolate <= latched.half_duplex_output_isolate & link.link_up &
                           link.speed_100 & ~link.ieee_full_duplex;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_er_idle <= 1'b0;
        end else begin
            rx_er_idle <= latched.idle_symbol_error_detect & link.idle_state &
                          link.rx_symbol_err;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rmii_rx_clk_ref <= 1'b0;
        end else begin
            rmii_rx_clk_ref <= latched.rmii_rx_clk_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit odd-nibble handling
    pssc_tx_nibble u_tx (
        .hclk(hclk),
        .hresetn(hresetn),
        .check_disable(latched.odd_nibble_check_disable),
        .tx_en_in(tx_en_in),
        .tx_er_in(tx_er_in),
        .tx_en_out(tx_en_out),
        .tx_er_out(tx_er_out)
    );

    ////////////////////////////////////////////////////////////////////////
    property p_reset_value;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> strap_two.rsvd_mid == 7'h02 && strap_two.rsvd_hi == 1'b0;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    property p_latch;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit(req, `PSSC_IDX_ONE) && req.wdata[`PSSC_ONE_CFG_DONE]
            |=> strap_reset_pulse ##1 !strap_reset_pulse &&
            latched == $past(strap_two | {9'h0, mdix_fast_any, 6'h0});
    endproperty
    a_latch: assert property (p_latch) else $error("straps not latched");

    property p_peer_drop;
        @(posedge hclk) disable iff (!hresetn)
        latched.peer_link_drop_on_failure && link.forced_100 && !link.link_up |=> tx_disable;
    endproperty
    a_peer_drop: assert property (p_peer_drop) else $error("tx not disabled");

    property p_fast_pd;
        @(posedge hclk) disable iff (!hresetn)
        ##1 fast_pd_link_up == $past(latched.fast_pd_link_up);
    endproperty
    a_fast_pd: assert property (p_fast_pd) else $error("fast link-up mismatch");

    property p_force_fast;
        @(posedge hclk) disable iff (!hresetn)
        mdix_fast_any |=> strap_two.fast_pd_link_up;
    endproperty
    a_force_fast: assert property (p_force_fast) else $error("fast link-up not forced");

    property p_ext_fd;
        @(posedge hclk) disable iff (!hresetn)
        latched.forced_partner_full_duplex_enable && link.partner_forced_100 &&
            link.forced_100 |=> duplex_full;
    endproperty
    a_ext_fd: assert property (p_ext_fd) else $error("full duplex not forced");

    property p_led;
        @(posedge hclk) disable iff (!hresetn)
        latched.led_link_full_duplex_only && !link.ieee_full_duplex |=> !led_link;
    endproperty
    a_led: assert property (p_led) else $error("led lit on half duplex");

    property p_isolate;
        @(posedge hclk) disable iff (!hresetn)
        mii_isolate |-> $past(latched.half_duplex_output_isolate) && $past(link.speed_100);
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolation without cause");

    property p_idle_err;
        @(posedge hclk) disable iff (!hresetn)
        rx_er_idle |-> $past(latched.idle_symbol_error_detect) && $past(link.rx_symbol_err);
    endproperty
    a_idle_err: assert property (p_idle_err) else $error("idle error without cause");

    property p_rmii;
        @(posedge hclk) disable iff (!hresetn)
        strap_reset_pulse |=> ##1 rmii_rx_clk_ref == $past(strap_two.rmii_rx_clk_ref, 2);
    endproperty
    a_rmii: assert property (p_rmii) else $error("rmii clock select wrong");

    c_latch: cover property (@(posedge hclk) disable iff (!hresetn) strap_reset_pulse);
    c_drop: cover property (@(posedge hclk) disable iff (!hresetn) $rose(tx_disable));
    c_isolate: cover property (@(posedge hclk) disable iff (!hresetn) $rose(mii_isolate));

endmodule

// ===== common/pssc_map.svh
// register offsets, field positions and reset values of the soft strap block
`ifndef PSSC_MAP_SVH
`define PSSC_MAP_SVH

// register indices; byte address is four times the index
`define PSSC_IDX_ONE 8'h09
`define PSSC_IDX_TWO 8'h0a
`define PSSC_IDX_STATUS 8'h0b
`define PSSC_IDX_NONE 8'hff

// first strap register fields kept by this block
`define PSSC_ONE_CFG_DONE 15
`define PSSC_ONE_FAST_MDIX 6
`define PSSC_ONE_ROBUST_MDIX 5
`define PSSC_ONE_RESET 16'h0000
`define PSSC_ONE_MDIX_RESET 2'h0

// second strap register fields
`define PSSC_TWO_PEER_DROP 15
`define PSSC_TWO_FAST_PD 6
`define PSSC_TWO_RESET 16'h0104

// status register fields
`define PSSC_STAT_CONFIGURED 16

// bus encodings
`define PSSC_HTRANS_NONSEQ_BIT 1
`define PSSC_HRESP_OKAY 1'h0

`endif

// ===== common/pssc_pkg.sv
// types shared by the soft strap block files
package pssc_pkg;

    // second strap register layout
    typedef struct packed {
        logic peer_link_drop_on_failure;
        logic rsvd_hi;
        logic [6:0] rsvd_mid;
        logic fast_pd_link_up;
        logic forced_partner_full_duplex_enable;
        logic led_link_full_duplex_only;
        logic half_duplex_output_isolate;
        logic idle_symbol_error_detect;
        logic odd_nibble_check_disable;
        logic rmii_rx_clk_ref;
    } pssc_two_s;

    // link state reported by the transceiver core
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic ieee_full_duplex;
        logic forced_100;
        logic auto_neg;
        logic partner_forced_100;
        logic idle_state;
        logic rx_symbol_err;
    } pssc_link_s;

    // register write request from the bus slave
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [31:0] wdata;
    } pssc_req_s;

    // bus slave states
    typedef enum logic [3:0] {
        PSSC_IDLE = 4'b0001,
        PSSC_WRITE = 4'b0010,
        PSSC_RD_WAIT = 4'b0100,
        PSSC_RD_DONE = 4'b1000
    } pssc_bus_e;

endpackage

// ===== design/pssc_ahb_slave.sv
// ahb-lite slave front end for the soft strap registers
`timescale 1ns/1ns
`include "pssc_map.svh"

module pssc_ahb_slave
    import pssc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output pssc_req_s req,
    output logic [7:0] rd_idx,
    input wire logic [31:0] rd_data
);

    pssc_bus_e state;
    pssc_bus_e next_state;
    logic accept;
    logic [7:0] idx;

    // only word transfers are issued, so hsize is not decoded
    assign accept = hsel & htrans[`PSSC_HTRANS_NONSEQ_BIT] & hready;
    assign hresp = `PSSC_HRESP_OKAY;
    // one wait state on reads so a write just before is already visible
    assign hreadyout = (state != PSSC_RD_WAIT);

    ////////////////////////////////////////////////////////////////////////
    // state sequencing
    always_comb begin
        next_state = PSSC_IDLE;
        if (accept) begin
            next_state = hwrite ? PSSC_WRITE : PSSC_RD_WAIT;
        end else if (state == PSSC_RD_WAIT) begin
            next_state = PSSC_RD_DONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= PSSC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // address phase capture; upper address bits set mean unmapped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx <= `PSSC_IDX_NONE;
        end else if (accept) begin
            idx <= (haddr[31:10] == 22'h0) ? haddr[9:2] : `PSSC_IDX_NONE;
        end
    end

    // read data loaded in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (state == PSSC_RD_WAIT) begin
            hrdata <= rd_data;
        end
    end

    // write committed at the end of its data phase
    assign req.wr = (state == PSSC_WRITE);
    assign req.idx = idx;
    assign req.wdata = hwdata;
    assign rd_idx = idx;

    ////////////////////////////////////////////////////////////////////////
    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

    property p_write_pulse;
        @(posedge hclk) disable iff (!hresetn)
        accept && hwrite |=> req.wr && hreadyout;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write not committed");

endmodule

// ===== design/pssc_tx_nibble.sv
// transmit odd-nibble boundary check with enable extension
`timescale 1ns/1ns

module pssc_tx_nibble (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic check_disable,
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    output logic tx_en_out,
    output logic tx_er_out
);

    logic tx_en_d;
    logic odd_count;
    logic extend;

    // odd_count is high when an odd number of nibbles has passed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            odd_count <= 1'b0;
            tx_en_d <= 1'b0;
        end else begin
            odd_count <= tx_en_in ? ~odd_count : 1'b0;
            tx_en_d <= tx_en_in;
        end
    end

    assign extend = tx_en_d & ~tx_en_in & odd_count & ~check_disable;

    // extra cycle is marked as an error cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
        end else begin
            tx_en_out <= tx_en_in | extend;
            tx_er_out <= (tx_er_in & tx_en_in) | extend;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // odd fall extended
    property p_odd_extend;
        @(posedge hclk) disable iff (!hresetn)
        tx_en_in ##1 !tx_en_in && !check_disable && $past(odd_count, 1) == 1'b0
            |=> tx_en_out && tx_er_out ##1 !tx_en_out;
    endproperty
    a_odd_extend: assert property (p_odd_extend) else $error("odd nibble not extended");

    property p_no_check;
        @(posedge hclk) disable iff (!hresetn)
        check_disable && tx_en_d && !tx_en_in |=> !tx_en_out;
    endproperty
    a_no_check: assert property (p_no_check) else $error("extension while disabled");

    c_extend: cover property (@(posedge hclk) disable iff (!hresetn) extend);

endmodule

// ===== tb/pssc_host_model.sv
// bus master model of the processor that sets up the strap registers
`timescale 1ns/1ns
`include "pssc_map.svh"

module pssc_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    ////////////////////////////////////////
    // bus idle from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////
    // one word transfer; no cycle count assumed, bounded by a wait limit
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        ok = 1'b1;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        hsize <= 3'h2;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        // released address lines show junk so stale values are never trusted
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        hwdata <= ~wd;
        ok = (hready === 1'b1);
    endtask

    ////////////////////////////////////////
    // reserved field at default
    task automatic configure(input logic [15:0] val, input logic [1:0] xover, output logic ok);
        logic [31:0] rd;
        logic ok2;
        xfer(1'b1, `PSSC_IDX_TWO, {16'h0, val[15], 1'b0, 7'h02, val[6:0]}, rd, ok);
        xfer(1'b1, `PSSC_IDX_ONE, {16'h0, 1'b1, 8'h0, xover, 5'h0}, rd, ok2);
        ok = ok & ok2;
    endtask
endmodule

// ===== tb/phy_soft_strap_control_two_tb.sv
// self-checking bench for the soft strap control block
`timescale 1ns/1ns
`include "pssc_map.svh"

module phy_soft_strap_control_two_tb;
    import pssc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_en_in, tx_en_out, tx_er_out;
    logic tx_er_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    pssc_link_s link;
    logic strap_reset_pulse, tx_disable, fast_pd_link_up, duplex_full, led_link;
    logic mii_isolate, rx_er_idle, rmii_rx_clk_ref;
    int error_cnt = 0;
    int check_count = 0;
    int pulse_cnt = 0;

    assign hready = hreadyout;

    pssc_top pssc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .link, .tx_en_in, .tx_er_in,
        .strap_reset_pulse, .tx_disable, .fast_pd_link_up, .duplex_full, .led_link,
        .mii_isolate, .rx_er_idle, .rmii_rx_clk_ref, .tx_en_out, .tx_er_out);

    pssc_host_model pssc_host_model_inst (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata);

    ////////////////////////////////////////
    // free running clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // cycles with the latch pulse high; one per config proves a single cycle
    always @(posedge hclk) begin
        if (strap_reset_pulse === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    ////////////////////////////////////////
    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a stuck bus ends the run at once
    task automatic bus_ok(input logic ok);
        check("bus_wait", {31'h0, ok}, 32'h1);
        if (ok !== 1'b1) begin
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] v;
        logic ok;
        pssc_host_model_inst.xfer(1'b1, idx, d, v, ok);
        bus_ok(ok);
    endtask

    task automatic rd(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        logic ok;
        pssc_host_model_inst.xfer(1'b0, idx, 32'h0, v, ok);
        bus_ok(ok);
        check(name, v, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic cfg(input logic [15:0] val, input logic [1:0] xover);
        logic ok;
        pssc_host_model_inst.configure(val, xover, ok);
        bus_ok(ok);
    endtask

    // effects lag the link by one edge, so look after the second
    task automatic eff(input string name, input logic [7:0] l, input logic [4:0] exp);
        link <= pssc_link_s'(l);
        repeat (2) @(posedge hclk);
        check(name, {27'h0, tx_disable, duplex_full, led_link, mii_isolate, rx_er_idle},
              {27'h0, exp});
    endtask

    // n nibbles of enable, then compare the delayed enable and error trace
    task automatic tx_walk(input int n, input logic ext);
        logic [15:0] en, er, exp_en, exp_er;
        en = 16'h0;
        er = 16'h0;
        exp_en = 16'h0;
        exp_er = 16'h0;
        for (int i = 0; i < n + 5; i++) begin
            @(posedge hclk);
            en[i] = tx_en_out;
            er[i] = tx_er_out;
            exp_en[i] = (i >= 2 && i <= n + 1) || (ext && i == n + 2);
            exp_er[i] = (ext && i == n + 2) || i == 2;
            tx_en_in <= (i < n);
            // error with the first nibble passes, error after the fall is gated off
            tx_er_in <= (i == 0 || i == n);
        end
        check("tx_en_out", {16'h0, en}, {16'h0, exp_en});
        check("tx_er_out", {16'h0, er}, {16'h0, exp_er});
    endtask

    ////////////////////////////////////////
    // reset values, read-only and unmapped places
    task automatic t_reset();
        rd("two_rst", `PSSC_IDX_TWO, 32'h0000_0104);
        rd("one_rst", `PSSC_IDX_ONE, 32'h0);
        rd("stat_rst", `PSSC_IDX_STATUS, 32'h0000_0104);
        wr(`PSSC_IDX_STATUS, 32'h0000_ffff);
        wr(`PSSC_IDX_NONE, 32'h0000_ffff);
        rd("unmapped", `PSSC_IDX_NONE, 32'h0);
        rd("stat_ro", `PSSC_IDX_STATUS, 32'h0000_0104);
        eff("rst_idle_err", 8'h03, 5'h01);
        eff("rst_idle_ok", 8'h02, 5'h00);
    endtask

    // every option on
    task automatic t_all_on();
        cfg(16'hffff, 2'h0);
        rd("two_all", `PSSC_IDX_TWO, 32'h0000_817f);
        rd("stat_all", `PSSC_IDX_STATUS, 32'h0001_817f);
        rd("one_done", `PSSC_IDX_ONE, 32'h0);
        check("pulses_a", pulse_cnt, 32'h1);
        check("fast_pd_a", {31'h0, fast_pd_link_up}, 32'h1);
        check("rmii_a", {31'h0, rmii_rx_clk_ref}, 32'h1);
        eff("a_forced_hd", 8'hd4, 5'h0a);
        eff("a_an_hd", 8'hcc, 5'h0a);
        eff("a_an_nopf", 8'hc8, 5'h02);
        eff("a_fd_idle", 8'hf7, 5'h0d);
        eff("a_drop", 8'h50, 5'h10);
        tx_walk(3, 1'b0);
    endtask

    // defaults only
    task automatic t_defaults();
        cfg(16'h0004, 2'h0);
        rd("stat_b", `PSSC_IDX_STATUS, 32'h0001_0104);
        check("fast_pd_b", {31'h0, fast_pd_link_up}, 32'h0);
        check("rmii_b", {31'h0, rmii_rx_clk_ref}, 32'h0);
        eff("b_hd", 8'hd4, 5'h04);
        eff("b_drop", 8'h50, 5'h00);
        tx_walk(3, 1'b1);
        tx_walk(2, 1'b0);
        tx_walk(1, 1'b1);
    endtask

    // crossover modes force the fast link-up bit; nothing latches without done
    task automatic t_xover();
        for (int k = 1; k < 3; k++) begin
            wr(`PSSC_IDX_ONE, {25'h0, 2'(k), 5'h0});
            rd("two_xover", `PSSC_IDX_TWO, 32'h0000_0144);
            rd("stat_hold", `PSSC_IDX_STATUS, 32'h0001_0104);
            wr(`PSSC_IDX_ONE, 32'h0);
            wr(`PSSC_IDX_TWO, 32'h0000_0104);
        end
        rd("two_free", `PSSC_IDX_TWO, 32'h0000_0104);
        cfg(16'h0000, 2'h2);
        rd("one_xover", `PSSC_IDX_ONE, 32'h0000_0040);
        check("fast_pd_x", {31'h0, fast_pd_link_up}, 32'h1);
        eff("c_idle_off", 8'h03, 5'h00);
        check("pulses_c", pulse_cnt, 32'h3);
    endtask

    ////////////////////////////////////////
    // reset, then the scenarios
    initial begin
        hresetn = 1'b0;
        link = pssc_link_s'(8'h0);
        tx_en_in = 1'b0;
        tx_er_in = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_all_on();
        t_defaults();
        t_xover();
        final_report();
    end
endmodule
